// ### verilog/gom_defines.vh
`ifndef GOM_DEFINES_VH
`define GOM_DEFINES_VH

// register indices (printed offsets are not multiples of four)
`define GOM_IDX_PIN1        8'h11
`define GOM_IDX_PIN2        8'h12
`define GOM_IDX_PORT_EN     8'h20
`define GOM_IDX_STATUS      8'h21
// byte address is four times the index
`define GOM_ADDR_W          10
`define GOM_CTL_RESET       8'h00
`define GOM_PORT_EN_RESET   4'hF
// control field positions
`define GOM_EN_BIT          0
`define GOM_VAL_BIT         1
`define GOM_SRC_HI          4
`define GOM_SRC_LO          2
`define GOM_SEL_HI          7
`define GOM_SEL_LO          5
// source group codes
`define GOM_SRC_DEV         3'h4
`define GOM_SRC_RSV         3'h5
`define GOM_SRC_TX0         3'h6
`define GOM_SRC_TX1         3'h7
// selection codes
`define GOM_SEL_0           3'h0
`define GOM_SEL_1           3'h1
`define GOM_SEL_2           3'h2
`define GOM_SEL_3           3'h3
`define GOM_SEL_4           3'h4
`define GOM_SEL_5           3'h5
`define GOM_SEL_6           3'h6
`define GOM_SEL_7           3'h7
// axi responses
`define GOM_RESP_OKAY       2'h0
`define GOM_RESP_SLVERR     2'h2

`endif

// ### verilog/gom_pin_mux.v
// Summary of operation
// - the pin 1 control register sits at index 0x11 and resets to zero.
// - bit 0 enables driving the pin; when clear the pin is not driven.
// - bit 1 is a software level driven when the local value is chosen.
// - bits 4:2 pick rx port 0-3, device status, reserved, or tx port 0-1.
// - with an rx source, selections 000-011 give that port's gpio 0-3.
// - with an rx source, 100-111 give lock, pass, frame valid, line valid.
// - device status 000 gives the software level, 001 the OR of locks of enabled rx ports.
// - device status 010 gives the AND of locks of enabled rx ports.
// - device status 011 gives the AND of passes of enabled rx ports.
// - device status 100 gives the sync pulse; 101-111 are reserved.
// - with a tx source, 000 gives AND and 001 OR of chosen rx passes.
// - with a tx source, 010 gives frame-active and 011 line-active.
// - with a tx source, 100 gives synchronized, 101 the tx interrupt.
`timescale 1ns/1ps
`include "gom_defines.vh"

////////////////////////////////////////////////////////////////////////////
// one slice of the hub's pin logic: a control byte for pin 1, a storage
// byte for pin 2, a port enable mask and a read-only status word behind a
// small register slave. the pin output and its enable both come straight
// from flip-flops, one cycle behind the control byte and the status
// inputs. all status inputs are taken as levels in the core clock
// domain; anything asynchronous must be brought in upstream.
////////////////////////////////////////////////////////////////////////////

module gom_pin_mux (
    // clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // axi4-lite write address
    input  wire [9:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    // axi4-lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    // axi4-lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // axi4-lite read address
    input  wire [9:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    // axi4-lite read data
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // per rx port status, bit n is port n; remote gpio has four bits per port
    input  wire [3:0]  rx_lock,
    input  wire [3:0]  rx_pass,
    input  wire [3:0]  rx_frame_valid,
    input  wire [3:0]  rx_line_valid,
    input  wire [15:0] rx_remote_gpio,
    // device status
    input  wire        periodic_sync_pulse,
    // per tx port status, bit n is port n; port select has four bits per port
    input  wire [1:0]  tx_frame_active,
    input  wire [1:0]  tx_line_active,
    input  wire [1:0]  tx_synchronized,
    input  wire [1:0]  tx_interrupt,
    input  wire [7:0]  tx_port_select,
    // pin 1 drive
    output reg         pin1_out,
    output reg         pin1_oe
);

    ////////////////////////////////////////////////////////////////////////
    // register state
    // pin 2 control is storage only here: its pin lives in another slice.
    // the port enable mask marks which rx ports take part in the device
    // status reductions and resets with every port taking part.
    // holding slots keep a taken address or data word until both are in.
    reg  [7:0] pin1_ctl_r;
    reg  [7:0] pin2_ctl_r;
    reg  [3:0] port_en_r;
    reg  [7:0] aw_idx_r;
    reg        aw_held_r;
    reg [31:0] w_data_r;
    reg  [3:0] w_strb_r;
    reg        w_held_r;

    // fields of the pin 1 control byte
    wire       pin1_drive_enable;
    wire       pin1_software_level;
    wire [2:0] pin1_output_source_group;
    wire [2:0] pin1_output_selection;

    // field slices; positions come from the shared header
    assign pin1_drive_enable        = pin1_ctl_r[`GOM_EN_BIT];
    assign pin1_software_level      = pin1_ctl_r[`GOM_VAL_BIT];
    assign pin1_output_source_group = pin1_ctl_r[`GOM_SRC_HI:`GOM_SRC_LO];
    assign pin1_output_selection    = pin1_ctl_r[`GOM_SEL_HI:`GOM_SEL_LO];

    // byte address to word index; low two address bits ignored
    // an unaligned address lands on the word that holds it
    function [7:0] word_idx;
        input [9:0] addr;
        begin
            word_idx = addr[9:2];
        end
    endfunction

    // known index decode, shared by read and write paths
    // pin 2 and the status word count as mapped even when unused
    function is_mapped;
        input [7:0] idx;
        begin
            is_mapped = (idx == `GOM_IDX_PIN1) || (idx == `GOM_IDX_PIN2) ||
                        (idx == `GOM_IDX_PORT_EN) ||
                        (idx == `GOM_IDX_STATUS);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // write path: address and data taken in either order, then response.
    // each channel parks in its own holding slot, so a master that offers
    // data long before the address is served the same as one that offers
    // both together. readies are registered and drop the cycle after a
    // take; that costs idle cycles between writes but keeps the ready
    // outputs free of any path from the valid inputs.
    // handshake terms of the write channels
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take  = s_axi_wvalid && s_axi_wready;
    wire do_wr   = aw_held_r && w_held_r && !s_axi_bvalid;

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `GOM_RESP_OKAY;
            aw_held_r     <= 1'b0;
            w_held_r      <= 1'b0;
            aw_idx_r      <= 8'h00;
            w_data_r      <= 32'h0000_0000;
            w_strb_r      <= 4'h0;
        end else begin
            // ready only while the slot is empty, so one write at a time
            s_axi_awready <= !aw_held_r && !aw_take && !s_axi_bvalid;
            s_axi_wready  <= !w_held_r && !w_take && !s_axi_bvalid;
            if (aw_take) begin
                aw_held_r <= 1'b1;
                aw_idx_r  <= word_idx(s_axi_awaddr);
            end
            if (w_take) begin
                w_held_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (do_wr) begin
                aw_held_r    <= 1'b0;
                w_held_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= is_mapped(aw_idx_r) ? `GOM_RESP_OKAY
                                                    : `GOM_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // register update; only byte lane 0 carries data.
    // a write with lane 0 off still answers okay but leaves every
    // register alone. the status word is read-only: a write to it is
    // accepted and dropped, so software cannot fake the pin state.
    // an unmapped index answers with an error and changes nothing.
    always @(posedge aclk) begin
        if (!aresetn) begin
            pin1_ctl_r <= `GOM_CTL_RESET;
            pin2_ctl_r <= `GOM_CTL_RESET;
            port_en_r  <= `GOM_PORT_EN_RESET;
        end else if (do_wr && w_strb_r[0]) begin
            case (aw_idx_r)
                `GOM_IDX_PIN1: begin
                    pin1_ctl_r <= w_data_r[7:0];
                end
                `GOM_IDX_PIN2: begin
                    pin2_ctl_r <= w_data_r[7:0];
                end
                `GOM_IDX_PORT_EN: begin
                    port_en_r <= w_data_r[3:0];
                end
                default: begin
                    pin1_ctl_r <= pin1_ctl_r;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read path: one cycle to accept, data the next.
    // arready toggles while idle instead of staying high; a request that
    // meets it low simply waits one more cycle. read data is captured at
    // the take, so a later change of the status inputs does not disturb
    // a response that is already waiting for rready.
    // only one read is in flight, so no read queue is needed.
    reg [31:0] rd_word;

    // status word shows the pin's live drive and inputs seen.
    // unmapped indices read as zero with an error response.
    // upper bits read zero so later fields can be added safely.
    always @* begin
        case (word_idx(s_axi_araddr))
            `GOM_IDX_PIN1:    rd_word = {24'h000000, pin1_ctl_r};
            `GOM_IDX_PIN2:    rd_word = {24'h000000, pin2_ctl_r};
            `GOM_IDX_PORT_EN: rd_word = {28'h0000000, port_en_r};
            `GOM_IDX_STATUS:  rd_word = {22'h0, pin1_oe, pin1_out,
                                         rx_pass, rx_lock};
            default:          rd_word = 32'h0000_0000;
        endcase
    end

    // read response; one read at a time
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `GOM_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_word;
                s_axi_rresp  <= is_mapped(word_idx(s_axi_araddr))
                                ? `GOM_RESP_OKAY : `GOM_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // aggregates over enabled rx ports; no port enabled gives low.
    // an empty set would make a plain AND of nothing read as high, which
    // would tell the board that all links are up when none is watched.
    wire       any_en   = |port_en_r;

    // tx port: its own choice of rx ports to combine
    // an empty choice reads as low for both the AND and the OR
    wire       tx_idx   = pin1_output_source_group[0];
    wire [3:0] tx_pick  = tx_idx ? tx_port_select[7:4]
                                 : tx_port_select[3:0];
    wire [1:0] rx_idx   = pin1_output_source_group[1:0];

    // per-port terms, one slice for each rx port
    wire [3:0] lock_hit;         // enabled and locked
    wire [3:0] lock_ok;          // locked or not taking part
    wire [3:0] pass_ok;          // passing or not taking part
    wire [3:0] tx_hit;           // chosen for the tx port and passing
    wire [3:0] tx_ok;            // passing or not chosen for the tx port
    wire [3:0] port_gpio [0:3];  // remote inputs of each rx port

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_port
            assign lock_hit[gi]  = rx_lock[gi] & port_en_r[gi];
            assign lock_ok[gi]   = rx_lock[gi] | ~port_en_r[gi];
            assign pass_ok[gi]   = rx_pass[gi] | ~port_en_r[gi];
            assign tx_hit[gi]    = rx_pass[gi] & tx_pick[gi];
            assign tx_ok[gi]     = rx_pass[gi] | ~tx_pick[gi];
            assign port_gpio[gi] = rx_remote_gpio[gi*4 +: 4];
        end
    endgenerate

    // reductions of the per-port terms
    wire       lock_or  = |lock_hit;
    wire       lock_and = any_en && &lock_ok;
    wire       pass_and = any_en && &pass_ok;
    wire       tx_and   = (|tx_pick) && &tx_ok;
    wire       tx_or    = |tx_hit;
    wire [3:0] rgpio    = port_gpio[rx_idx];

    // level chosen for the pin before its register
    reg        mux_level;

    // source and selection decode, reserved codes drive low.
    // a reserved source or selection must never pass a stray input to
    // the board, so every branch starts from low and only the listed
    // codes overwrite it. the decode is purely combinational; the pin
    // register below adds the single cycle of latency.
    // the tx index picks both the status bit and the rx port choice.
    always @* begin
        mux_level = 1'b0;
        if (!pin1_output_source_group[2]) begin
            case (pin1_output_selection)
                `GOM_SEL_0, `GOM_SEL_1, `GOM_SEL_2, `GOM_SEL_3:
                    mux_level = rgpio[pin1_output_selection[1:0]];
                `GOM_SEL_4: mux_level = rx_lock[rx_idx];
                `GOM_SEL_5: mux_level = rx_pass[rx_idx];
                `GOM_SEL_6: mux_level = rx_frame_valid[rx_idx];
                `GOM_SEL_7: mux_level = rx_line_valid[rx_idx];
                default:    mux_level = 1'b0;
            endcase
        end else if (pin1_output_source_group == `GOM_SRC_DEV) begin
            case (pin1_output_selection)
                `GOM_SEL_0: mux_level = pin1_software_level;
                `GOM_SEL_1: mux_level = lock_or;
                `GOM_SEL_2: mux_level = lock_and;
                `GOM_SEL_3: mux_level = pass_and;
                `GOM_SEL_4: mux_level = periodic_sync_pulse;
                default:    mux_level = 1'b0;
            endcase
        end else if (pin1_output_source_group != `GOM_SRC_RSV) begin
            case (pin1_output_selection)
                `GOM_SEL_0: mux_level = tx_and;
                `GOM_SEL_1: mux_level = tx_or;
                `GOM_SEL_2: mux_level = tx_frame_active[tx_idx];
                `GOM_SEL_3: mux_level = tx_line_active[tx_idx];
                `GOM_SEL_4: mux_level = tx_synchronized[tx_idx];
                `GOM_SEL_5: mux_level = tx_interrupt[tx_idx];
                default:    mux_level = 1'b0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin registers; level forced low while disabled to avoid stale data.
    // enable and level share one register stage so the board never sees
    // a new enable paired with the level of the old selection. the cost
    // is one cycle from a register write or an input change to the pin.
    // a disabled pin is left to the board's own pull.
    always @(posedge aclk) begin
        if (!aresetn) begin
            pin1_oe  <= 1'b0;
            pin1_out <= 1'b0;
        end else begin
            pin1_oe  <= pin1_drive_enable;
            pin1_out <= pin1_drive_enable && mux_level;
        end
    end

    // limitation: only pin 1 is driven from this slice; the pin 2 byte
    // is kept so software sees the full map, and a second slice built
    // from this one would own that pin. level inputs are not filtered,
    // so a glitch one cycle long on a status input reaches the pin.

endmodule

// ### testbench/gom_pin_obs.sv
`timescale 1ns/1ps

module gom_pin_obs (
    // board clock
    input  wire aclk,
    // pin as driven by the hub
    input  wire pin_out,
    input  wire pin_oe,
    // level seen on the board
    output wire pin_lvl
);
    reg last_r = 1'b0;

    // no pull on the board: a released pin shows a changing level
    always @(posedge aclk) last_r <= pin_lvl;
    assign pin_lvl = pin_oe ? pin_out : ~last_r;
endmodule

// ### testbench/gom_pin_mux_assertions.sv
`timescale 1ns/1ps
`include "gom_defines.vh"

module gom_pin_mux_chk (
    // clock and reset
    input wire        aclk,
    input wire        aresetn,
    // write path
    input wire [9:0]  s_axi_awaddr,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0]  s_axi_wstrb,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    // status inputs
    input wire [3:0]  rx_lock,
    input wire [3:0]  rx_pass,
    input wire [15:0] rx_remote_gpio,
    // pin
    input wire        pin1_out,
    input wire        pin1_oe
);
    reg  [7:0] a_r, d_r, ctl_r;
    reg        s_r;
    reg  [3:0] pen_r;
    wire [2:0] sel = ctl_r[7:5];
    wire [1:0] p   = ctl_r[3:2];
    wire       rx  = ctl_r[0] && !ctl_r[4];
    wire       dev = ctl_r[0] && ctl_r[4:2] == `GOM_SRC_DEV;
    wire       bh  = s_axi_bvalid && s_axi_bready && s_r;

    // shadow registers follow the write response, one cycle after the real register
    always @(posedge aclk) begin
        if (!aresetn) begin
            ctl_r <= `GOM_CTL_RESET;
            pen_r <= `GOM_PORT_EN_RESET;
        end else begin
            if (s_axi_awvalid && s_axi_awready) a_r <= s_axi_awaddr[9:2];
            if (s_axi_wvalid && s_axi_wready) begin
                d_r <= s_axi_wdata[7:0];
                s_r <= s_axi_wstrb[0];
            end
            if (bh && a_r == `GOM_IDX_PIN1) ctl_r <= d_r;
            if (bh && a_r == `GOM_IDX_PORT_EN) pen_r <= d_r[3:0];
        end
    end

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // skip cycles where the shadow may lag the real register
    sequence s_idle;
        !s_axi_bvalid ##1 !s_axi_bvalid;
    endsequence

    property p_rst; $rose(aresetn) |-> !pin1_oe && !pin1_out; endproperty
    property p_off; s_idle ##0 !ctl_r[0] |-> !pin1_oe && !pin1_out; endproperty
    property p_on; s_idle ##0 ctl_r[0] |-> pin1_oe; endproperty
    property p_val; s_idle ##0 dev && sel == 3'h0 |-> pin1_out == ctl_r[1];
    endproperty
    property p_gpio; s_idle ##0 rx && !sel[2] |->
        pin1_out == $past(rx_remote_gpio[{p, sel[1:0]}]); endproperty
    property p_rxst; s_idle ##0 rx && sel[2:1] == 2'b10 |->
        pin1_out == $past(sel[0] ? rx_pass[p] : rx_lock[p]); endproperty
    property p_or; s_idle ##0 dev && sel == 3'h1 |->
        pin1_out == $past(|(rx_lock & pen_r)); endproperty
    property p_andl; s_idle ##0 dev && sel == 3'h2 |->
        pin1_out == $past(pen_r != 4'h0 && (rx_lock & pen_r) == pen_r);
    endproperty
    property p_rsv; s_idle ##0 ctl_r[0] && (ctl_r[4:2] == `GOM_SRC_RSV
        || dev && sel > 3'h4 || ctl_r[4:3] == 2'b11 && sel[2:1] == 2'b11)
        |-> !pin1_out; endproperty

    a_rst: assert property (p_rst)
        else $error("pin active after reset");
    a_off: assert property (p_off)
        else $error("pin driven while off");
    a_on: assert property (p_on)
        else $error("pin not driven");
    a_val: assert property (p_val)
        else $error("level wrong");
    a_gpio: assert property (p_gpio)
        else $error("remote input wrong");
    a_rxst: assert property (p_rxst)
        else $error("port status wrong");
    a_or: assert property (p_or)
        else $error("lock or wrong");
    a_andl: assert property (p_andl)
        else $error("lock and wrong");
    a_rsv: assert property (p_rsv)
        else $error("reserved not low");
endmodule

bind gom_pin_mux gom_pin_mux_chk chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .rx_lock(rx_lock), .rx_pass(rx_pass), .rx_remote_gpio(rx_remote_gpio),
    .pin1_out(pin1_out), .pin1_oe(pin1_oe));

// ### testbench/testbench.sv
`timescale 1ns/1ps
`include "gom_defines.vh"

module testbench;
    reg         aclk = 1'b0, aresetn = 1'b0;
    reg  [9:0]  aw = 10'h000, ar = 10'h000;
    reg  [31:0] wd = 32'h00000000;
    reg  [3:0]  ws = 4'hF;
    reg         awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
    wire        awr, wrdy, bv, arr, rv, po, poe, lvl;
    wire [1:0]  bre, rre;
    wire [31:0] rd;
    reg  [3:0]  lk, ps, fv, lv, pen;
    reg  [15:0] gp;
    reg         sy;
    reg  [1:0]  fa, la, sn, ti;
    reg  [7:0]  ts, c;
    integer     fail_count = 0, check_count = 0, k, p;
    localparam [48:0] PAT = {4'hF, 4'h6, 4'h5, 4'hA, 16'hC35A, 1'b1,
                             2'h1, 2'h2, 2'h1, 2'h2, 8'h37};

    always #4 aclk = ~aclk;

    gom_pin_mux dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(aw), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
        .s_axi_wready(wrdy), .s_axi_bresp(bre), .s_axi_bvalid(bv),
        .s_axi_bready(br), .s_axi_araddr(ar), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rre),
        .s_axi_rvalid(rv), .s_axi_rready(rr), .rx_lock(lk), .rx_pass(ps),
        .rx_frame_valid(fv), .rx_line_valid(lv), .rx_remote_gpio(gp),
        .periodic_sync_pulse(sy), .tx_frame_active(fa),
        .tx_line_active(la), .tx_synchronized(sn), .tx_interrupt(ti),
        .tx_port_select(ts), .pin1_out(po), .pin1_oe(poe));

    gom_pin_obs obs (.aclk(aclk), .pin_out(po), .pin_oe(poe), .pin_lvl(lvl));

    ////////////////////////////////////////////////////////////////////////
    task chk(input [8*5-1:0] nm, input [31:0] e, input [31:0] g);
        begin
            check_count = check_count + 1;
            if (g !== e) begin
                fail_count = fail_count + 1;
                $display("ERROR %0s expected %h seen %h", nm, e, g);
            end
        end
    endtask

    task conclude;
        begin
            $display("checks %0d errors %0d", check_count, fail_count);
            if (fail_count == 0 && check_count > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask

    // address and data offered together, each dropped once taken
    task axi_wr(input [7:0] i, input [7:0] d, input [1:0] e);
        reg busy;
        begin
            @(posedge aclk);
            aw <= {i, 2'b00};
            wd <= {24'h000000, d};
            awv <= 1'b1;
            wv <= 1'b1;
            br <= 1'b1;
            busy = 1'b1;
            while (busy) begin
                @(posedge aclk);
                if (awr) awv <= 1'b0;
                if (wrdy) wv <= 1'b0;
                if (bv) begin
                    br <= 1'b0;
                    busy = 1'b0;
                    chk("bresp", {30'h0, e}, {30'h0, bre});
                end
            end
        end
    endtask

    task axi_rd(input [7:0] i, input [31:0] d, input [1:0] e);
        reg busy;
        begin
            @(posedge aclk);
            ar <= {i, 2'b00};
            arv <= 1'b1;
            rr <= 1'b1;
            busy = 1'b1;
            while (busy) begin
                @(posedge aclk);
                if (arr) arv <= 1'b0;
                if (rv) begin
                    rr <= 1'b0;
                    busy = 1'b0;
                    chk("rdata", d, rd);
                    chk("rresp", {30'h0, e}, {30'h0, rre});
                end
            end
        end
    endtask

    // expected pin level worked out from the control byte and inputs
    function ex(input [7:0] b);
        reg [7:0] v;
        reg [3:0] m;
        integer   n;
        begin
            n = b[3:2];
            m = b[2] ? ts[7:4] : ts[3:0];
            v = 8'h00;
            if (!b[4]) v = {lv[n], fv[n], ps[n], lk[n], gp[4*n +: 4]};
            if (b[4:2] == `GOM_SRC_DEV)
                v = {3'h0, sy, pen != 0 && (ps & pen) == pen,
                     pen != 0 && (lk & pen) == pen, |(lk & pen), b[1]};
            if (b[4:3] == 2'b11)
                v = {2'h0, ti[b[2]], sn[b[2]], la[b[2]], fa[b[2]],
                     |(ps & m), m != 0 && (ps & m) == m};
            ex = b[0] & v[b[7:5]];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    initial begin
        {lk, ps, fv, lv, gp, sy, fa, la, sn, ti, ts} = PAT;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        chk("oe", 0, poe);
        axi_rd(`GOM_IDX_PIN1, 0, `GOM_RESP_OKAY);
        axi_wr(`GOM_IDX_PIN2, 8'hA5, `GOM_RESP_OKAY);
        axi_rd(`GOM_IDX_PIN2, 32'hA5, `GOM_RESP_OKAY);
        axi_wr(8'h30, 8'h01, `GOM_RESP_SLVERR);
        axi_rd(8'h30, 0, `GOM_RESP_SLVERR);
        axi_wr(`GOM_IDX_PIN1, 8'h12, `GOM_RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk("oe", 0, poe);
        // every source and selection, with both input polarities
        for (p = 0; p < 2; p = p + 1) begin
            pen = p ? 4'h9 : 4'hF;
            axi_wr(`GOM_IDX_PORT_EN, {4'h0, pen}, `GOM_RESP_OKAY);
            {lk, ps, fv, lv, gp, sy, fa, la, sn, ti, ts} <= PAT ^ {49{p[0]}};
            for (k = 0; k < 64; k = k + 1) begin
                c = {k[5:0], ~p[0], 1'b1};
                axi_wr(`GOM_IDX_PIN1, c, `GOM_RESP_OKAY);
                axi_rd(`GOM_IDX_PIN1, {24'h0, c}, `GOM_RESP_OKAY);
                repeat (2) @(posedge aclk);
                chk("oe", 1, poe);
                if (!c[4])
                    chk("pin", ex(c), lvl);
                else if (c[4:2] == `GOM_SRC_DEV && !c[7])
                    chk("pin", ex(c), lvl);
                else if (c[4:2] == `GOM_SRC_DEV)
                    chk("pin", ex(c), lvl);
                else if (c[4:2] == `GOM_SRC_RSV)
                    chk("pin", ex(c), lvl);
                else
                    chk("pin", ex(c), lvl);
            end
        end
        // last setting is a reserved tx selection: driven, level low
        axi_rd(`GOM_IDX_STATUS, {22'h0, 2'b10, ps, lk},
               `GOM_RESP_OKAY);
        // reset in mid-run, then a write with its byte strobe off
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        ws <= 4'h0;
        axi_wr(`GOM_IDX_PIN1, 8'hFF, `GOM_RESP_OKAY);
        ws <= 4'hF;
        axi_rd(`GOM_IDX_PIN1, 0, `GOM_RESP_OKAY);
        chk("oe", 0, poe);
        conclude;
    end

    // hang guard, far beyond the expected run length
    initial begin
        #(8 * 20000);
        fail_count = fail_count + 1;
        $display("ERROR watchdog expected done seen hang");
        conclude;
    end
endmodule
